// ===== qit_counter.v
// One counting core with its output logic for the quad interval timer.
`timescale 1ns/1ps
`default_nettype none
`include "qit_defines.vh"
module qit_counter (
	input  wire        clk_in,
	input  wire        rstn_in,
	input  wire        ce_in,
	input  wire        rise_in,
	input  wire        fall_in,
	input  wire        gate_in,
	input  wire        prog_in,
	input  wire        arm_in,
	input  wire        hold_in,
	input  wire [2:0]  mode_in,
	input  wire [15:0] init_in,
	output reg  [15:0] count_out,
	output reg         out_out,
	output reg         loaded_out
);
	reg gate_s;
	reg trig;
	reg pend;
	reg busy;

	always @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			count_out  <= 16'h0000;
			out_out    <= 1'b0;
			loaded_out <= 1'b0;
			gate_s     <= 1'b0;
			trig       <= 1'b0;
			pend       <= 1'b0;
			busy       <= 1'b0;
		end
		else if (ce_in)
		begin
			loaded_out <= 1'b0;
			if (rise_in)
			begin
				gate_s <= gate_in;
				if (gate_in && !gate_s)
					trig <= 1'b1;
				if (!gate_in && (mode_in == `QIT_MODE_RATE || mode_in == `QIT_MODE_SQUARE))
					out_out <= 1'b1;
			end
			if (prog_in)
			begin
				out_out <= (mode_in == `QIT_MODE_TC) ? 1'b0 : 1'b1;
				pend    <= 1'b0;
				busy    <= 1'b0;
				trig    <= 1'b0;
			end
			else if (hold_in && mode_in == `QIT_MODE_TC)
			begin
				// First byte of a two-byte count stops counting at once.
				out_out <= 1'b0;
				pend    <= 1'b0;
				busy    <= 1'b0;
			end
			else if (arm_in)
			begin
				if (mode_in == `QIT_MODE_TC)
				begin
					out_out <= 1'b0;
					pend    <= 1'b1;
				end
				else if (mode_in == `QIT_MODE_ONESHOT || !busy)
					pend <= 1'b1;
			end
			else if (fall_in)
			begin
				case (mode_in)
					`QIT_MODE_ONESHOT:
					begin
						if (trig && (pend || busy))
						begin
							count_out  <= init_in;
							loaded_out <= 1'b1;
							out_out    <= 1'b0;
							trig       <= 1'b0;
							pend       <= 1'b0;
							busy       <= 1'b1;
						end
						else if (busy)
						begin
							count_out <= count_out - 16'h0001;
							if (count_out == 16'h0001)
								out_out <= 1'b1;
						end
					end
					`QIT_MODE_RATE:
					begin
						if (pend || trig || (busy && gate_s && count_out == 16'h0001))
						begin
							count_out  <= init_in;
							loaded_out <= 1'b1;
							out_out    <= 1'b1;
							trig       <= 1'b0;
							pend       <= 1'b0;
							busy       <= 1'b1;
						end
						else if (busy && gate_s)
						begin
							count_out <= count_out - 16'h0001;
							out_out   <= (count_out != 16'h0002);
						end
					end
					`QIT_MODE_SQUARE:
					begin
						if (pend || trig)
						begin
							count_out  <= init_in;
							loaded_out <= 1'b1;
							out_out    <= 1'b1;
							trig       <= 1'b0;
							pend       <= 1'b0;
							busy       <= 1'b1;
						end
						else if (busy && gate_s)
						begin
							if (count_out <= 16'h0002)
							begin
								count_out  <= init_in;
								loaded_out <= 1'b1;
								out_out    <= !out_out;
							end
							else
								count_out <= count_out - 16'h0002;
						end
					end
					default:
					begin
						trig <= 1'b0;
						if (pend)
						begin
							count_out  <= init_in;
							loaded_out <= 1'b1;
							pend       <= 1'b0;
							busy       <= 1'b1;
						end
						else if (busy && gate_s)
						begin
							count_out <= count_out - 16'h0001;
							if (count_out == 16'h0001)
								out_out <= 1'b1;
						end
					end
				endcase
			end
		end
	end
endmodule // qit_counter
`default_nettype wire

// ===== qit_defines.vh
// Register offsets, control word fields and reset values of the quad interval timer.
//
// Function
// - Four timers 0-3 share one counting clock, otherwise fully independent.
// - Each counter takes its own mode; counters may run different modes together.
// - Rising edge of timer zero output raises tick interrupt; no pin for it.
// - Timer one rising edge requests refresh when enabled; disabled after reset.
// - Timer two pin is two-way; low driven from outside raises interrupt three.
// - Timer three output edge raises interrupt zero; inverse drives a pin.
// - Control word one governs timers 0-2; control word two governs timer 3.
// - Both control word registers are write-only; reads return no contents.
// - Each counting core is a 16-bit down counter preset from the holding pair.
// - Snapshot bytes track the core; a latch command freezes them until read.
// - Count reads return one snapshot byte per access, never the core itself.
// - Count writes fill holding bytes singly; both load into the core together.
// - Programming clears both holding bytes, so a one-byte count loads zero in the byte not written.
// - Latched status gives control word contents, output level and null flag.
// - Pins of timers two and three carry the inverse of the counter output.
// - Gate sampled on counting clock rise; load and decrement on its fall.
// - Gates 0,1 tied high; gates 2,3 follow control port bits 0,6; reset low.
// - Terminal count mode: output low on write, high after load plus N pulses.
// - Rate mode: output low one pulse at count one, then reload and repeat.
`ifndef QIT_DEFINES_VH
`define QIT_DEFINES_VH

`define QIT_IDX_CW1      3'h4
`define QIT_IDX_CW2      3'h5
`define QIT_IDX_CTRL     3'h6
`define QIT_IDX_STAT     3'h7

`define QIT_CW_SC        7:6
`define QIT_CW_RW        5:4
`define QIT_CW_MODE      3:1
`define QIT_CW_BCD       0
`define QIT_RB_NCOUNT    5
`define QIT_RB_NSTATUS   4
`define QIT_RB_CW2_SEL   1
`define QIT_SC_READBACK  2'h3

`define QIT_RW_LATCH     2'h0
`define QIT_RW_LOW       2'h1
`define QIT_RW_HIGH      2'h2
`define QIT_RW_BOTH      2'h3

`define QIT_MODE_TC      3'h0
`define QIT_MODE_ONESHOT 3'h1
`define QIT_MODE_RATE    3'h2
`define QIT_MODE_SQUARE  3'h3

`define QIT_CTRL_GATE2   0
`define QIT_CTRL_REFEN   1
`define QIT_CTRL_GATE3   6
`define QIT_CTRL_RESET   8'h00

`endif

// ===== qit_pin_env.sv
// Pin-side model: counting clock source and the open-collector timer two wire.
`timescale 1ns/1ps
`default_nettype none
module qit_pin_env (
	input  wire logic clk_in,
	input  wire logic drive_in,
	input  wire logic oe_in,
	input  wire logic ext_low_in,
	output logic      count_clk_out,
	output logic      pin_out
);
	// The wire idles high through the pull-up; either party may pull it low.
	assign pin_out = ((oe_in && !drive_in) || ext_low_in) ? 1'b0 : 1'b1;
	initial count_clk_out = 1'b0;
	// One pulse is a rise then a fall, each level far longer than the synchroniser.
	task pulse;
		begin
			@(posedge clk_in);
			count_clk_out <= 1'b1;
			repeat (4) @(posedge clk_in);
			count_clk_out <= 1'b0;
			repeat (8) @(posedge clk_in);
		end
	endtask
endmodule // qit_pin_env
`default_nettype wire

// ===== qit_timer_core.v
// Top of the quad interval timer: bus slave, count paths, gates and output routing.
`timescale 1ns/1ps
`default_nettype none
`include "qit_defines.vh"
module qit_timer_core (
	input  wire        core_clk_in,
	input  wire        rstn_in,
	input  wire        ce_in,
	input  wire [4:0]  avs_address_in,
	input  wire        avs_read_in,
	input  wire        avs_write_in,
	input  wire [31:0] avs_writedata_in,
	input  wire [3:0]  avs_byteenable_in,
	output reg  [31:0] avs_readdata_out,
	output wire        avs_waitrequest_out,
	input  wire        shared_count_clock_in,
	input  wire        timer_two_pin_inverted_in,
	output wire        timer_two_pin_inverted_out,
	output reg         timer_two_pin_inverted_oe_out,
	output reg         timer_one_pin_out,
	output reg         refresh_request_out,
	output reg         timer_three_pin_inverted_out,
	output reg         tick_interrupt_request_out,
	output reg         pin_driven_interrupt_request_out,
	output reg         timer_three_interrupt_request_out
);
	// Maps a control word to the counter it programs.
	function [1:0] cw_index;
		input       is_two;
		input [1:0] sc;
		begin
			cw_index = is_two ? 2'h3 : sc;
		end
	endfunction

	// Tells whether a read-back command selects counter idx.
	function rb_sel;
		input       is_two;
		input [7:0] d;
		input [1:0] idx;
		begin
			if (is_two)
				rb_sel = (idx == 2'h3) && d[`QIT_RB_CW2_SEL];
			else
				rb_sel = (idx != 2'h3) && d[idx + 2'h1];
		end
	endfunction

	// Folds the mode field: modes six and seven act as rate and square wave.
	function [2:0] mode_fold;
		input [2:0] m;
		begin
			case (m)
				3'h6:    mode_fold = `QIT_MODE_RATE;
				3'h7:    mode_fold = `QIT_MODE_SQUARE;
				default: mode_fold = m;
			endcase
		end
	endfunction

	// Tells whether the next count read returns the high snapshot byte.
	function rd_high;
		input [1:0] rw;
		input       hi;
		begin
			rd_high = (rw == `QIT_RW_HIGH) || (rw == `QIT_RW_BOTH && hi);
		end
	endfunction

	reg         ack;
	reg  [2:0]  clk_sync;
	reg  [1:0]  pin_sync;
	reg  [7:0]  ctrl;
	reg  [3:0]  prog;
	reg  [3:0]  arm;
	reg  [3:0]  hold;
	reg  [3:0]  wr_hi;
	reg  [3:0]  rd_hi;
	reg  [3:0]  frozen;
	reg  [3:0]  st_lat;
	reg  [3:0]  nullf;
	reg  [3:0]  bcd;
	reg  [3:0]  out_prev;
	reg  [2:0]  drv_hist;
	reg  [2:0]  mode     [0:3];
	reg  [1:0]  rwm      [0:3];
	reg  [7:0]  hold_lo  [0:3];
	reg  [7:0]  hold_hi  [0:3];
	reg  [15:0] snap     [0:3];
	reg  [7:0]  stat     [0:3];
	reg  [7:0]  rv;
	wire [63:0] cnt_bus;
	wire [3:0]  outs;
	wire [3:0]  loaded;
	wire [3:0]  gates;
	wire        req;
	wire        take;
	wire        aligned;
	wire [2:0]  widx;
	wire [1:0]  cidx;
	wire [7:0]  wd;
	wire        wr_ok;
	wire        rd_take;
	wire        is_cnt;
	wire        is_two;
	wire [1:0]  cw_k;
	wire        cnt_rise;
	wire        cnt_fall;
	integer     i;

	// Each access is answered one cycle after it is presented.
	assign req                 = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~ack;
	assign take                = req & ack;
	assign aligned             = (avs_address_in[1:0] == 2'h0);
	assign widx                = avs_address_in[4:2];
	assign cidx                = avs_address_in[3:2];
	assign is_cnt              = ~widx[2];
	assign wd                  = avs_writedata_in[7:0];
	assign wr_ok               = avs_write_in & take & aligned & avs_byteenable_in[0];
	assign rd_take             = avs_read_in & take & aligned;
	assign is_two              = (widx == `QIT_IDX_CW2);
	assign cw_k                = cw_index(is_two, wd[`QIT_CW_SC]);
	assign cnt_rise            = clk_sync[1] & ~clk_sync[2];
	assign cnt_fall            = ~clk_sync[1] & clk_sync[2];
	assign gates               = {ctrl[`QIT_CTRL_GATE3], ctrl[`QIT_CTRL_GATE2], 2'b11};
	assign timer_two_pin_inverted_out = 1'b0;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : cnt_gen
			qit_counter u_cnt (
				.clk_in     (core_clk_in),
				.rstn_in    (rstn_in),
				.ce_in      (ce_in),
				.rise_in    (cnt_rise),
				.fall_in    (cnt_fall),
				.gate_in    (gates[g]),
				.prog_in    (prog[g]),
				.arm_in     (arm[g]),
				.hold_in    (hold[g]),
				.mode_in    (mode[g]),
				.init_in    ({hold_hi[g], hold_lo[g]}),
				.count_out  (cnt_bus[16*g +: 16]),
				.out_out    (outs[g]),
				.loaded_out (loaded[g])
			);
		end
	endgenerate

	// Counting clock and the timer two pin come from outside this clock domain.
	always @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			clk_sync <= 3'h0;
			pin_sync <= 2'h3;
		end
		else if (ce_in)
		begin
			clk_sync <= {clk_sync[1:0], shared_count_clock_in};
			pin_sync <= {pin_sync[0], timer_two_pin_inverted_in};
		end
	end

	// Read value selection; control words never read back.
	always @*
	begin
		rv = 8'h00;
		if (is_cnt)
		begin
			if (st_lat[cidx])
				rv = stat[cidx];
			else if (rd_high(rwm[cidx], rd_hi[cidx]))
				rv = snap[cidx][15:8];
			else
				rv = snap[cidx][7:0];
		end
		else if (widx == `QIT_IDX_CTRL)
			rv = ctrl;
		else if (widx == `QIT_IDX_STAT)
			rv = {nullf, outs};
	end

	always @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			ack              <= 1'b0;
			avs_readdata_out <= 32'h00000000;
			ctrl             <= `QIT_CTRL_RESET;
			prog             <= 4'h0;
			arm              <= 4'h0;
			hold             <= 4'h0;
			wr_hi            <= 4'h0;
			rd_hi            <= 4'h0;
			frozen           <= 4'h0;
			st_lat           <= 4'h0;
			nullf            <= 4'h0;
			bcd              <= 4'h0;
			for (i = 0; i < 4; i = i + 1)
			begin
				mode[i]    <= `QIT_MODE_TC;
				rwm[i]     <= `QIT_RW_LATCH;
				hold_lo[i] <= 8'h00;
				hold_hi[i] <= 8'h00;
				snap[i]    <= 16'h0000;
				stat[i]    <= 8'h00;
			end
		end
		else if (ce_in)
		begin
			ack  <= req & ~ack;
			prog <= 4'h0;
			arm  <= 4'h0;
			hold <= 4'h0;
			if (avs_read_in && !ack)
				avs_readdata_out <= {24'h000000, rv};
			for (i = 0; i < 4; i = i + 1)
			begin
				if (!frozen[i])
					snap[i] <= cnt_bus[16*i +: 16];
				if (loaded[i])
					nullf[i] <= 1'b0;
			end
			if (rd_take && is_cnt)
			begin
				if (st_lat[cidx])
					st_lat[cidx] <= 1'b0;
				else if (rwm[cidx] == `QIT_RW_BOTH)
				begin
					rd_hi[cidx] <= ~rd_hi[cidx];
					if (rd_hi[cidx])
						frozen[cidx] <= 1'b0;
				end
				else
					frozen[cidx] <= 1'b0;
			end
			if (wr_ok)
			begin
				if (is_cnt)
				begin
					nullf[cidx] <= 1'b1;
					case (rwm[cidx])
						`QIT_RW_LOW:
						begin
							hold_lo[cidx] <= wd;
							arm[cidx]     <= 1'b1;
						end
						`QIT_RW_HIGH:
						begin
							hold_hi[cidx] <= wd;
							arm[cidx]     <= 1'b1;
						end
						`QIT_RW_BOTH:
						begin
							wr_hi[cidx] <= ~wr_hi[cidx];
							if (wr_hi[cidx])
							begin
								hold_hi[cidx] <= wd;
								arm[cidx]     <= 1'b1;
							end
							else
							begin
								hold_lo[cidx] <= wd;
								hold[cidx]    <= 1'b1;
							end
						end
						default:
							nullf[cidx] <= 1'b0;
					endcase
				end
				else if (widx == `QIT_IDX_CTRL)
					ctrl <= wd;
				else if (widx == `QIT_IDX_CW1 || widx == `QIT_IDX_CW2)
				begin
					if (wd[`QIT_CW_SC] == `QIT_SC_READBACK)
					begin
						for (i = 0; i < 4; i = i + 1)
						begin
							if (rb_sel(is_two, wd, i[1:0]))
							begin
								if (!wd[`QIT_RB_NCOUNT] && !frozen[i])
									frozen[i] <= 1'b1;
								if (!wd[`QIT_RB_NSTATUS] && !st_lat[i])
								begin
									st_lat[i] <= 1'b1;
									stat[i]   <= {outs[i], nullf[i], rwm[i], mode[i], bcd[i]};
								end
							end
						end
					end
					else if (wd[`QIT_CW_RW] == `QIT_RW_LATCH)
					begin
						if (!frozen[cw_k])
							frozen[cw_k] <= 1'b1;
					end
					else
					begin
						// Modes six and seven alias rate and square wave.
						mode[cw_k]    <= mode_fold(wd[`QIT_CW_MODE]);
						rwm[cw_k]     <= wd[`QIT_CW_RW];
						bcd[cw_k]     <= wd[`QIT_CW_BCD];
						hold_lo[cw_k] <= 8'h00;
						hold_hi[cw_k] <= 8'h00;
						wr_hi[cw_k]   <= 1'b0;
						rd_hi[cw_k]   <= 1'b0;
						frozen[cw_k]  <= 1'b0;
						st_lat[cw_k]  <= 1'b0;
						prog[cw_k]    <= 1'b1;
					end
				end
			end
		end
	end

	// Output routing and edge detectors on the counter outputs.
	always @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			out_prev                          <= 4'h0;
			drv_hist                          <= 3'h0;
			timer_two_pin_inverted_oe_out     <= 1'b0;
			timer_one_pin_out                 <= 1'b0;
			refresh_request_out               <= 1'b0;
			timer_three_pin_inverted_out      <= 1'b1;
			tick_interrupt_request_out        <= 1'b0;
			pin_driven_interrupt_request_out  <= 1'b0;
			timer_three_interrupt_request_out <= 1'b0;
		end
		else if (ce_in)
		begin
			out_prev                          <= outs;
			drv_hist                          <= {drv_hist[1:0], outs[2]};
			tick_interrupt_request_out        <= outs[0] & ~out_prev[0];
			timer_one_pin_out                 <= outs[1];
			refresh_request_out               <= outs[1] & ~out_prev[1] & ctrl[`QIT_CTRL_REFEN];
			// Open-collector: pull low while the inverted output is low.
			timer_two_pin_inverted_oe_out     <= outs[2];
			// Our own pull-down needs three cycles to clear the pin synchroniser.
			pin_driven_interrupt_request_out  <= ~|{pin_sync[1], outs[2], drv_hist};
			timer_three_pin_inverted_out      <= ~outs[3];
			timer_three_interrupt_request_out <= outs[3] & ~out_prev[3];
		end
	end
endmodule // qit_timer_core
`default_nettype wire

// ===== qit_timer_core_assertions.sv
// Concurrent checks on the ports of the quad interval timer core.
`timescale 1ns/1ps
`default_nettype none
module qit_timer_core_assertions (
	input wire logic        core_clk_in,
	input wire logic        rstn_in,
	input wire logic [4:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        timer_two_pin_inverted_out,
	input wire logic        timer_two_pin_inverted_oe_out,
	input wire logic        timer_one_pin_out,
	input wire logic        refresh_request_out,
	input wire logic        timer_three_pin_inverted_out,
	input wire logic        tick_interrupt_request_out,
	input wire logic        pin_driven_interrupt_request_out,
	input wire logic        timer_three_interrupt_request_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rstn_in);

	property p_read_wait;
		$rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read answer late");

	property p_byte_wide;
		avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0;
	endproperty
	a_byte_wide: assert property (p_byte_wide) else $error("read wider than a byte");

	property p_cw_write_only;
		avs_read_in && !avs_waitrequest_out
			&& (avs_address_in == 5'h10 || avs_address_in == 5'h14)
			|-> avs_readdata_out == 32'h0;
	endproperty
	a_cw_write_only: assert property (p_cw_write_only) else $error("control word readable");

	property p_tick_pulse;
		tick_interrupt_request_out |=> !tick_interrupt_request_out;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick request too long");

	property p_timer_three_interrupt_request_edge;
		timer_three_interrupt_request_out
			|-> !timer_three_pin_inverted_out ##1 !timer_three_interrupt_request_out;
	endproperty
	a_timer_three_interrupt_request_edge: assert property (p_timer_three_interrupt_request_edge) else $error("timer three request wrong");

	property p_refresh_edge;
		refresh_request_out |-> timer_one_pin_out ##1 !refresh_request_out;
	endproperty
	a_refresh_edge: assert property (p_refresh_edge) else $error("refresh request wrong");

	property p_pin_irq_input;
		pin_driven_interrupt_request_out |-> !$past(timer_two_pin_inverted_oe_out);
	endproperty
	a_pin_irq_input: assert property (p_pin_irq_input) else $error("pin request while driving");

	property p_open_collector;
		timer_two_pin_inverted_oe_out |-> !timer_two_pin_inverted_out;
	endproperty
	a_open_collector: assert property (p_open_collector) else $error("pin driven high");
endmodule // qit_timer_core_assertions

bind qit_timer_core qit_timer_core_assertions qit_timer_core_assertions_inst (
	.core_clk_in(core_clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.timer_two_pin_inverted_out(timer_two_pin_inverted_out),
	.timer_two_pin_inverted_oe_out(timer_two_pin_inverted_oe_out),
	.timer_one_pin_out(timer_one_pin_out), .refresh_request_out(refresh_request_out),
	.timer_three_pin_inverted_out(timer_three_pin_inverted_out),
	.tick_interrupt_request_out(tick_interrupt_request_out),
	.pin_driven_interrupt_request_out(pin_driven_interrupt_request_out),
	.timer_three_interrupt_request_out(timer_three_interrupt_request_out));
`default_nettype wire

// ===== tb_qit_timer_core.sv
// Self-checking bench for the quad interval timer core.
`timescale 1ns/1ps
`default_nettype none
module tb_qit_timer_core;
	logic        clk;
	logic        rstn;
	logic [4:0]  addr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        wait_req;
	logic        pin;
	logic        two_drv;
	logic        two_oe;
	logic        one_pin;
	logic        refr;
	logic        three_pin;
	logic        tick;
	logic        pin_irq;
	logic        timer_three_interrupt_request;
	logic        cclk;
	logic        ext_low;
	logic        out1;
	logic        prev1;
	logic [7:0]  q;
	integer      miscompares = 0;
	integer      checked = 0;
	integer      ticks = 0;
	integer      irq0s = 0;
	integer      refs = 0;
	integer      ref_exp = 0;
	integer      n0;
	integer      n1;
	integer      k;
	integer      v;
	integer      lat;

	qit_timer_core qit_timer_core_inst (.core_clk_in(clk), .rstn_in(rstn), .ce_in(1'b1),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_req), .shared_count_clock_in(cclk),
		.timer_two_pin_inverted_in(pin), .timer_two_pin_inverted_out(two_drv),
		.timer_two_pin_inverted_oe_out(two_oe), .timer_one_pin_out(one_pin),
		.refresh_request_out(refr), .timer_three_pin_inverted_out(three_pin),
		.tick_interrupt_request_out(tick), .pin_driven_interrupt_request_out(pin_irq),
		.timer_three_interrupt_request_out(timer_three_interrupt_request));
	qit_pin_env qit_pin_env_inst (.clk_in(clk), .drive_in(two_drv), .oe_in(two_oe),
		.ext_low_in(ext_low), .count_clk_out(cclk), .pin_out(pin));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (rstn === 1'b1)
		begin
			ticks <= ticks + tick;
			irq0s <= irq0s + timer_three_interrupt_request;
			refs <= refs + refr;
		end
	end

	task print_verdict;
		begin
			if (miscompares == 0 && checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			checked++;
			if (seen !== exp)
			begin
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
				miscompares++;
			end
		end
	endtask

	// One Avalon transfer, held until waitrequest is sampled low.
	task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		integer n;
		begin
			@(posedge clk);
			addr <= a;
			wdata <= {24'h0, d};
			wr <= w;
			rd <= !w;
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end while (wait_req !== 1'b0 && n < 50);
			q = rdata[7:0];
			if (n >= 50)
			begin
				miscompares++;
				print_verdict;
			end
			wr <= 1'b0;
			rd <= 1'b0;
		end
	endtask

	task wrw(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task rdc(input logic [4:0] a, input logic [7:0] e);
		begin
			bus(1'b0, a, 8'h00);
			check(q, e);
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict;
	end

	initial
	begin
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		ext_low = 1'b0;
		n0 = $urandom(32'h9f67a175);
		n0 = 2 + $urandom % 4;
		n1 = 3 + $urandom % 4;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		check(one_pin, 1'b0);
		check(three_pin, 1'b1);
		rdc(5'h18, 8'h00);
		// A full count first, then a low byte only: the stale high byte must be gone.
		wrw(5'h10, 8'h30);
		wrw(5'h00, 8'hff);
		wrw(5'h00, 8'hff);
		wrw(5'h10, 8'h10);
		wrw(5'h00, n0[7:0]);
		wrw(5'h10, 8'h74);
		wrw(5'h04, n1[7:0]);
		wrw(5'h04, 8'h00);
		wrw(5'h10, 8'h90);
		wrw(5'h08, 8'h50);
		wrw(5'h14, 8'h10);
		wrw(5'h0c, 8'h02);
		wrw(5'h18, 8'h43);
		wrw(5'h19, 8'hff);
		rdc(5'h18, 8'h43);
		rdc(5'h10, 8'h00);
		rdc(5'h14, 8'h00);
		wrw(5'h10, 8'he2);
		rdc(5'h00, 8'h50);
		prev1 = 1'b1;
		for (k = 1; k <= 10; k++)
		begin
			qit_pin_env_inst.pulse;
			v = n1 - ((k - 1) % n1);
			out1 = (v != 1);
			if (out1 && !prev1)
				ref_exp++;
			prev1 = out1;
			check(ticks, k > n0);
			check(irq0s, k > 2);
			check(three_pin, k <= 2);
			check(one_pin, out1);
			check(refs, ref_exp);
			if (k == 1)
			begin
				wrw(5'h10, 8'he2);
				rdc(5'h00, 8'h10);
			end
			if (k == 4 || k == 7)
				lat = v;
			if (k == 4)
				wrw(5'h10, 8'h40);
			if (k == 5 || k == 7)
			begin
				rdc(5'h04, lat[7:0]);
				rdc(5'h04, lat[15:8]);
			end
		end
		check(two_oe, 1'b0);
		rdc(5'h1c, {6'h02, out1, 1'b1});
		ext_low <= 1'b1;
		repeat (6) @(posedge clk);
		check(pin_irq, 1'b1);
		ext_low <= 1'b0;
		repeat (6) @(posedge clk);
		check(pin_irq, 1'b0);
		// Square wave of four on counter two, gate-triggered one-shot of three on counter three.
		wrw(5'h10, 8'h96);
		wrw(5'h08, 8'h04);
		wrw(5'h14, 8'h12);
		wrw(5'h0c, 8'h03);
		wrw(5'h18, 8'h03);
		qit_pin_env_inst.pulse;
		wrw(5'h18, 8'h43);
		for (k = 1; k <= 8; k++)
		begin
			qit_pin_env_inst.pulse;
			check(two_oe, (k % 4) < 2);
			check(three_pin, k <= 3);
			check(pin_irq, 1'b0);
		end
		// A second reset in mid-run brings the gates and pins back to their idle state.
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		check(one_pin, 1'b0);
		check(three_pin, 1'b1);
		rdc(5'h18, 8'h00);
		print_verdict;
	end
endmodule // tb_qit_timer_core
`default_nettype wire
